//--- hw/bcsp_parser.sv
// Command stream parser: fetch, decode and execute command dwords
`default_nettype none
module bcsp_parser
	import bcsp_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rstn,
	// AXI4-Lite slave
	input  wire logic [7:0]  s_awaddr,
	input  wire logic        s_awvalid,
	output var  logic        s_awready,
	input  wire logic [31:0] s_wdata,
	input  wire logic [3:0]  s_wstrb,
	input  wire logic        s_wvalid,
	output var  logic        s_wready,
	output var  logic [1:0]  s_bresp,
	output var  logic        s_bvalid,
	input  wire logic        s_bready,
	input  wire logic [7:0]  s_araddr,
	input  wire logic        s_arvalid,
	output var  logic        s_arready,
	output var  logic [31:0] s_rdata,
	output var  logic [1:0]  s_rresp,
	output var  logic        s_rvalid,
	input  wire logic        s_rready,
	// Command fetch
	output var  logic        fetchReq,
	output var  logic [31:0] fetchAddr,
	output var  logic        fetchGlobal,
	input  wire logic        fetchValid,
	input  wire logic [31:0] fetchData,
	// Engines and memory side effects
	input  wire logic        enginesIdle,
	input  wire logic        semPass,
	output var  logic        memWrValid,
	output var  bcsp_mw_s    memWr,
	input  wire logic        memWrReady,
	output var  logic        regWrValid,
	output var  bcsp_rw_s    regWr,
	input  wire logic        regWrReady,
	output var  logic        tlbInvalidate,
	output var  logic        cachePurge,
	output var  logic        syncIrq,
	output var  logic        pmIdle
);
	// ------------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------------
	localparam logic [7:0] A_CTRL  = 8'h00; // bit0 run, bit1 pp enable
	localparam logic [7:0] A_RHEAD = 8'h04;
	localparam logic [7:0] A_MODE  = 8'h08;
	localparam logic [7:0] A_IRQEN = 8'h0C;
	localparam logic [7:0] A_TAG   = 8'h10;
	localparam logic [7:0] A_STAT  = 8'h14;
	localparam logic [7:0] A_ADDR  = 8'h18;

	typedef enum {
		ST_IDLE, ST_HDR, ST_DW, ST_EXEC, ST_DRAIN, ST_MWR, ST_CFG,
		ST_RWR, ST_SEM, ST_SKIP
	} bcsp_state_e;

	bcsp_state_e state_r;
	logic [31:0] hdr_r, dw1_r, dw2_r, dw3_r;
	logic [7:0]  need_r, got_r;
	logic [31:0] pc_r, ringHead_r, mode_r, tag_r;
	logic        run_r, ppEn_r, irqEn_r, secure_r;
	logic [63:0] tsNow;
	logic [5:0]  opc;

	logic        awHeld_r, wHeld_r;
	logic [7:0]  awAddr_r;
	logic [31:0] wData_r;

	bcsp_ts_counter i_bcsp_ts_counter (
		.clk   (clk),
		.rstn  (rstn),
		.count (tsNow)
	);

	// Length plus bias; dwords after the header
	function automatic logic [7:0] cmdLen(input logic [31:0] h);
		logic [5:0] o;
		o = h[28:23];
		if (o == OP_FLUSH || o == OP_LRI || o == OP_MBOX || o == OP_CHAIN)
			return h[7:0] + 8'(BIAS_TWO) - 8'h01;
		return 8'(BIAS_ONE) - 8'h01;
	endfunction : cmdLen

	assign opc = hdr_r[28:23];

	// ------------------------------------------------------------------
	// Bus slave
	// ------------------------------------------------------------------
	logic doWr;
	assign s_awready = !awHeld_r && !s_bvalid;
	assign s_wready  = !wHeld_r && !s_bvalid;
	assign doWr      = awHeld_r && wHeld_r;
	assign s_bresp   = 2'b00;
	assign s_rresp   = 2'b00;
	assign s_arready = !s_rvalid;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			awHeld_r <= 1'b0;
			wHeld_r  <= 1'b0;
			awAddr_r <= '0;
			wData_r  <= '0;
			s_bvalid <= 1'b0;
		end else begin
			if (s_awvalid && s_awready) begin
				awHeld_r <= 1'b1;
				awAddr_r <= s_awaddr;
			end
			if (s_wvalid && s_wready) begin
				wHeld_r <= 1'b1;
				wData_r <= s_wdata;
			end
			if (doWr) begin
				awHeld_r <= 1'b0;
				wHeld_r  <= 1'b0;
				s_bvalid <= 1'b1;
			end else if (s_bready) begin
				s_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			run_r      <= 1'b0;
			ppEn_r     <= 1'b0;
			ringHead_r <= '0;
			mode_r     <= '0;
			irqEn_r    <= 1'b0;
		end else if (doWr) begin
			if (awAddr_r == A_CTRL) begin
				run_r  <= wData_r[0];
				ppEn_r <= wData_r[1];
			end else if (awAddr_r == A_RHEAD) begin
				ringHead_r <= wData_r;
			end else if (awAddr_r == A_MODE) begin
				mode_r <= wData_r;
			end else if (awAddr_r == A_IRQEN) begin
				irqEn_r <= wData_r[0];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			s_rvalid <= 1'b0;
			s_rdata  <= '0;
		end else if (s_arvalid && s_arready) begin
			s_rvalid <= 1'b1;
			if (s_araddr == A_CTRL)
				s_rdata <= {30'h0, ppEn_r, run_r};
			else if (s_araddr == A_RHEAD)
				s_rdata <= ringHead_r;
			else if (s_araddr == A_MODE)
				s_rdata <= mode_r;
			else if (s_araddr == A_IRQEN)
				s_rdata <= {31'h0, irqEn_r};
			else if (s_araddr == A_TAG)
				s_rdata <= tag_r;
			else if (s_araddr == A_STAT)
				s_rdata <= {30'h0, secure_r, state_r == ST_IDLE};
			else if (s_araddr == A_ADDR)
				s_rdata <= pc_r;
			else
				s_rdata <= '0;
		end else if (s_rready) begin
			s_rvalid <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// Fetch and decode
	// ------------------------------------------------------------------
	assign fetchReq    = (state_r == ST_HDR || state_r == ST_DW);
	assign fetchAddr   = pc_r;
	assign fetchGlobal = secure_r;
	assign pmIdle      = (state_r == ST_IDLE || state_r == ST_SEM);

	logic        fl_tlb, fl_ps_ok, fl_purge;
	logic [1:0]  fl_ps;
	assign fl_ps    = hdr_r[15:14];
	assign fl_ps_ok = (fl_ps == PS_IMM || fl_ps == PS_TIME);
	assign fl_tlb   = hdr_r[BIT_TLBINV] && fl_ps_ok;
	assign fl_purge = hdr_r[BIT_PURGE] && fl_ps_ok;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			state_r  <= ST_IDLE;
			pc_r     <= '0;
			hdr_r    <= '0;
			dw1_r    <= '0;
			dw2_r    <= '0;
			dw3_r    <= '0;
			need_r   <= '0;
			got_r    <= '0;
			secure_r <= 1'b1;
			tag_r    <= '0;
		end else begin
			case (state_r)
			ST_IDLE: begin
				if (run_r && pc_r != ringHead_r)
					state_r <= ST_HDR;
			end
			ST_HDR: begin
				if (fetchValid) begin
					hdr_r  <= fetchData;
					need_r <= cmdLen(fetchData);
					got_r  <= '0;
					pc_r   <= pc_r + 32'h4;
					state_r <= (cmdLen(fetchData) == 8'h00) ? ST_EXEC : ST_DW;
				end
			end
			ST_DW: begin
				if (fetchValid) begin
					if (got_r == 8'h00) dw1_r <= fetchData;
					if (got_r == 8'h01) dw2_r <= fetchData;
					if (got_r == 8'h02) dw3_r <= fetchData;
					got_r <= got_r + 8'h01;
					pc_r  <= pc_r + 32'h4;
					if (got_r + 8'h01 == need_r)
						state_r <= ST_EXEC;
				end
			end
			ST_EXEC: begin
				if (opc == OP_CHAIN) begin
					pc_r <= {dw1_r[31:2], 2'b00};
					// A per-process list stays per-process
					secure_r <= secure_r && !hdr_r[BIT_SPACE];
					state_r <= ST_IDLE;
				end else if (opc == OP_FLUSH) begin
					state_r <= ST_DRAIN;
				end else if (opc == OP_LRI) begin
					state_r <= ST_RWR;
				end else if (opc == OP_REPHEAD) begin
					state_r <= ST_MWR;
				end else if (opc == OP_MBOX) begin
					state_r <= ST_SEM;
				end else begin
					if (opc == OP_PAD && hdr_r[BIT_TAGEN])
						tag_r <= {10'h000, hdr_r[21:0]};
					state_r <= ST_IDLE;
				end
			end
			ST_DRAIN: begin
				if (enginesIdle) begin
					if (fl_ps == PS_NONE || fl_ps == 2'h2)
						state_r <= ST_IDLE;
					else
						state_r <= ST_MWR;
				end
			end
			ST_MWR: begin
				if (memWrReady) begin
					if (opc == OP_FLUSH && fl_tlb && mode_r[MODE_CFGW])
						state_r <= ST_CFG;
					else
						state_r <= ST_IDLE;
				end
			end
			ST_CFG, ST_RWR: begin
				if (regWrReady || !regWrValid)
					state_r <= ST_IDLE;
			end
			ST_SEM: begin
				if (semPass)
					state_r <= ST_IDLE;
			end
			default: state_r <= ST_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Side effects
	// ------------------------------------------------------------------
	always_comb begin
		memWr         = '0;
		memWrValid    = (state_r == ST_MWR);
		regWrValid    = 1'b0;
		regWr         = '0;
		if (opc == OP_FLUSH) begin
			memWr.addr    = {dw1_r[31:3], 3'b000};
			memWr.qword   = (fl_ps == PS_IMM) && (hdr_r[7:0] == 8'h02);
			memWr.data    = (fl_ps == PS_TIME) ? tsNow
				: {dw3_r, dw2_r};
			memWr.glob    = dw1_r[BIT_DSTG];
			memWr.index   = hdr_r[BIT_INDEX];
			memWr.ppIndex = hdr_r[BIT_INDEX] && !secure_r && ppEn_r;
		end else begin
			memWr.data  = {32'h0, ringHead_r};
			memWr.index = 1'b1;
			memWr.glob  = 1'b1;
		end
		if (state_r == ST_CFG) begin
			regWrValid = 1'b1;
			regWr.offs = CFG_OFFSET[31:2];
			regWr.data = CFG_DATA;
		end else if (state_r == ST_RWR) begin
			regWrValid = (hdr_r[11:8] != BD_ALL);
			regWr.offs = dw1_r[31:2];
			regWr.data = dw2_r;
			regWr.be   = ~hdr_r[11:8];
		end
	end

	logic flushDone;
	assign flushDone = (state_r == ST_DRAIN) && enginesIdle;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			tlbInvalidate <= 1'b0;
			cachePurge    <= 1'b0;
			syncIrq       <= 1'b0;
		end else begin
			tlbInvalidate <= flushDone && fl_tlb;
			cachePurge    <= flushDone && fl_purge;
			syncIrq       <= flushDone && hdr_r[BIT_NOTIFY] && irqEn_r;
		end
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	flush_stall_a: assert property (@(posedge clk) disable iff (!rstn)
		state_r == ST_DRAIN && !enginesIdle |=> state_r == ST_DRAIN)
		else $error("Flush left before engines idle");
	chain_pp_a: assert property (@(posedge clk) disable iff (!rstn)
		state_r == ST_EXEC && opc == OP_CHAIN && !secure_r |=> !secure_r)
		else $error("Per-process list reached global space");
	chain_addr_a: assert property (@(posedge clk) disable iff (!rstn)
		state_r == ST_EXEC && opc == OP_CHAIN
		|=> pc_r == {$past(dw1_r[31:2]), 2'b00})
		else $error("Chained start address wrong");
	tag_load_a: assert property (@(posedge clk) disable iff (!rstn)
		state_r == ST_EXEC && opc == OP_PAD && !hdr_r[BIT_TAGEN]
		|=> $stable(tag_r))
		else $error("Tag changed without enable");
	tlb_code_a: assert property (@(posedge clk) disable iff (!rstn)
		tlbInvalidate |-> $past(fl_ps) == PS_IMM || $past(fl_ps) == PS_TIME)
		else $error("Invalidation with wrong post-write code");
	bd_suppress_a: assert property (@(posedge clk) disable iff (!rstn)
		state_r == ST_RWR && hdr_r[11:8] == BD_ALL |-> !regWrValid)
		else $error("Suppressed register write issued");
	irq_gate_a: assert property (@(posedge clk) disable iff (!rstn)
		syncIrq |-> $past(irqEn_r) && $past(hdr_r[BIT_NOTIFY]))
		else $error("Sync interrupt not enabled");
	sem_idle_a: assert property (@(posedge clk) disable iff (!rstn)
		state_r == ST_SEM |-> pmIdle && !memWrValid && !regWrValid)
		else $error("Semaphore wait not idle");
endmodule : bcsp_parser
`default_nettype wire

//--- hw/bcsp_pkg.sv
// Package for the blit command stream parser: opcodes, fields, constants
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
`default_nettype none
package bcsp_pkg;
	localparam logic [5:0]  OP_PAD     = 6'h00;
	localparam logic [5:0]  OP_REPHEAD = 6'h07;
	localparam logic [5:0]  OP_MBOX    = 6'h16;
	localparam logic [5:0]  OP_LRI     = 6'h22;
	localparam logic [5:0]  OP_FLUSH   = 6'h26;
	localparam logic [5:0]  OP_CHAIN   = 6'h31;
	localparam logic [1:0]  PS_NONE    = 2'h0;
	localparam logic [1:0]  PS_IMM     = 2'h1;
	localparam logic [1:0]  PS_TIME    = 2'h3;
	localparam logic [3:0]  BD_ALL     = 4'hF;
	localparam int          BIT_SPACE  = 8;
	localparam int          BIT_NOTIFY = 8;
	localparam int          BIT_TAGEN  = 22;
	localparam int          BIT_INDEX  = 21;
	localparam int          BIT_TLBINV = 18;
	localparam int          BIT_PURGE  = 17;
	localparam int          BIT_DSTG   = 2;
	localparam int          MODE_CFGW  = 13;
	localparam logic [31:0] CFG_OFFSET = 32'h0004_F100;
	localparam logic [31:0] CFG_DATA   = 32'h0000_0001;
	localparam logic [3:0]  BIAS_ONE   = 4'h1;
	localparam logic [3:0]  BIAS_TWO   = 4'h2;
	localparam int          TS_NS      = 80;
	localparam int          CLK_NS     = 25;
	localparam int          TS_CYC     = (TS_NS + CLK_NS - 1) / CLK_NS;
	localparam int          TS_BITS    = 36;

	typedef struct packed {
		logic [31:0] addr;
		logic [63:0] data;
		logic        qword;
		logic        glob;
		logic        index;
		logic        ppIndex;
	} bcsp_mw_s;

	typedef struct packed {
		logic [29:0] offs;
		logic [31:0] data;
		logic [3:0]  be;
	} bcsp_rw_s;
endpackage : bcsp_pkg
`default_nettype wire

//--- hw/bcsp_ts_counter.sv
// Time counter ticking every 4 clocks (100 ns granularity) with upper bits tied low
`default_nettype none
module bcsp_ts_counter
	import bcsp_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              rstn,
	output var  logic [63:0]       count
);
	localparam int DIVW = $clog2(TS_CYC + 1);

	logic [DIVW-1:0]             div_r;
	logic [TS_BITS-1:0]          cnt_r;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			div_r <= '0;
			cnt_r <= '0;
		end else if (div_r == DIVW'(TS_CYC - 1)) begin
			div_r <= '0;
			cnt_r <= cnt_r + 1'b1;
		end else begin
			div_r <= div_r + 1'b1;
		end
	end

	assign count = {28'h000_0000, cnt_r};
endmodule : bcsp_ts_counter
`default_nettype wire

//--- tb/bcsp_mem_model.sv
// Command memory partner: answers fetches and post-writes after a delay
`default_nettype none
module bcsp_mem_model
	import bcsp_pkg::*;
#(
	parameter int DLY = 2
)(
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        fetchReq,
	input  wire logic [31:0] fetchAddr,
	output var  logic        fetchValid,
	output var  logic [31:0] fetchData,
	input  wire logic        memWrValid,
	output var  logic        memWrReady
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] mem [0:511];
	int          fetchCnt_r;
	int          wrCnt_r;

	initial begin
		for (int i = 0; i < 512; i++) begin
			mem[i] = 32'h0000_0000;
		end
	end

	always_ff @(posedge clk) begin
		fetchValid <= 1'b0;
		memWrReady <= 1'b0;
		// Data toggles outside a beat so stale words never look valid
		fetchData <= ~fetchData;
		if (!rstn) begin
			fetchCnt_r <= 0;
			wrCnt_r <= 0;
			fetchData <= 32'h0000_0000;
		end else begin
			fetchCnt_r <= 0;
			wrCnt_r <= 0;
			if (fetchReq && !fetchValid) begin
				fetchCnt_r <= fetchCnt_r + 1;
				if (fetchCnt_r == DLY) begin
					fetchValid <= 1'b1;
					fetchData <= mem[fetchAddr[10:2]];
					fetchCnt_r <= 0;
				end
			end
			if (memWrValid && !memWrReady) begin
				wrCnt_r <= wrCnt_r + 1;
				if (wrCnt_r == DLY + 1) begin
					memWrReady <= 1'b1;
					wrCnt_r <= 0;
				end
			end
		end
	end
endmodule : bcsp_mem_model
`default_nettype wire

//--- tb/tb_bcsp_parser.sv
// Self-checking testbench for the command stream parser
`default_nettype none
module tb_bcsp_parser
	import bcsp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rstn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
	logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
	logic [7:0] s_awaddr, s_araddr;
	logic [31:0] s_wdata, s_rdata, fetchAddr, fetchData, r;
	logic [3:0] s_wstrb;
	logic [1:0] s_bresp, s_rresp;
	logic fetchReq, fetchGlobal, fetchValid, enginesIdle, semPass;
	logic memWrValid, memWrReady, regWrValid, regWrReady;
	logic tlbInvalidate, cachePurge, syncIrq, pmIdle;
	bcsp_mw_s memWr;
	bcsp_rw_s regWr;
	bcsp_mw_s mwq[$];
	bcsp_rw_s rwq[$];
	int tlbCnt, irqCnt, purgeCnt, cycles, fail_count, checks, wp;

	bcsp_parser i_bcsp_parser (.clk, .rstn, .s_awaddr, .s_awvalid,
		.s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp,
		.s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata,
		.s_rresp, .s_rvalid, .s_rready, .fetchReq, .fetchAddr, .fetchGlobal,
		.fetchValid, .fetchData, .enginesIdle, .semPass, .memWrValid, .memWr,
		.memWrReady, .regWrValid, .regWr, .regWrReady, .tlbInvalidate,
		.cachePurge, .syncIrq, .pmIdle);
	bcsp_mem_model #(.DLY(2)) i_bcsp_mem_model (.clk, .rstn, .fetchReq,
		.fetchAddr, .fetchValid, .fetchData, .memWrValid, .memWrReady);

	always #12.5 clk = ~clk;

	always @(posedge clk) begin
		cycles++;
		if (memWrValid === 1'b1 && memWrReady === 1'b1) mwq.push_back(memWr);
		if (regWrValid === 1'b1 && regWrReady === 1'b1) rwq.push_back(regWr);
		if (tlbInvalidate === 1'b1) tlbCnt++;
		if (syncIrq === 1'b1) irqCnt++;
		if (cachePurge === 1'b1) purgeCnt++;
		if (cycles == 30000) begin
			fail_count++;
			summarize();
		end
	end

	// ------------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------------
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic summarize();
		$display("checks=%0d fail_count=%0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : summarize

	// Handshakes are judged at the falling edge, acted on at the rising one
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		logic ta, tw, tb;
		@(posedge clk);
		s_awaddr <= a;
		s_wdata <= d;
		s_awvalid <= 1'b1;
		s_wvalid <= 1'b1;
		s_bready <= 1'b1;
		forever begin
			@(negedge clk);
			ta = s_awvalid & s_awready;
			tw = s_wvalid & s_wready;
			tb = s_bvalid & s_bready;
			if (tb) chk(s_bresp, 2'b00);
			@(posedge clk);
			if (ta) s_awvalid <= 1'b0;
			if (tw) s_wvalid <= 1'b0;
			if (tb) begin
				s_bready <= 1'b0;
				break;
			end
		end
	endtask : axw

	task automatic axr(input logic [7:0] a, output logic [31:0] d);
		logic ta, tr;
		d = 32'h0000_0000;
		@(posedge clk);
		s_araddr <= a;
		s_arvalid <= 1'b1;
		s_rready <= 1'b1;
		forever begin
			@(negedge clk);
			ta = s_arvalid & s_arready;
			tr = s_rvalid & s_rready;
			if (tr) d = s_rdata;
			if (tr) chk(s_rresp, 2'b00);
			@(posedge clk);
			if (ta) s_arvalid <= 1'b0;
			if (tr) begin
				s_rready <= 1'b0;
				break;
			end
		end
	endtask : axr

	task automatic put(input logic [31:0] d);
		i_bcsp_mem_model.mem[wp] = d;
		wp++;
	endtask : put

	function automatic logic [31:0] hdr(input logic [5:0] op,
		input logic [22:0] low);
		return {3'h0, op, low};
	endfunction : hdr

	task automatic clr();
		mwq.delete();
		rwq.delete();
		tlbCnt = 0;
		irqCnt = 0;
		purgeCnt = 0;
	endtask : clr

	// Idle alone also shows between commands; the list end is pc at head
	task automatic waitIdle();
		logic [31:0] pc;
		int          n;
		n = 0;
		do begin
			axr(8'h18, pc);
			axr(8'h14, r);
			n++;
		end while ((r[0] !== 1'b1 || pc !== 32'(wp * 4)) && n < 100);
		chk(r[0], 1'b1);
		chk(pc, 32'(wp * 4));
		repeat (8) @(posedge clk);
	endtask : waitIdle

	task automatic go();
		axw(8'h04, 32'(wp * 4));
		waitIdle();
	endtask : go

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task automatic s_tag();
		clr();
		put(hdr(OP_PAD, 23'h6A_BCDE));
		put(hdr(OP_PAD, 23'h15_5555));
		go();
		axr(8'h10, r);
		chk(r[21:0], 22'h2A_BCDE);
	endtask : s_tag

	task automatic s_regw();
		clr();
		put(hdr(OP_LRI, 23'h00_0001));
		put(32'h0000_048C);
		put(32'hCAFE_F00D);
		put(hdr(OP_LRI, 23'h00_0F01));
		put(32'h0000_0490);
		put(32'h1111_2222);
		put(hdr(OP_PAD, 23'h40_0077));
		regWrReady <= 1'b0;
		axw(8'h04, 32'(wp * 4));
		repeat (60) @(posedge clk);
		axr(8'h10, r);
		chk(r[21:0], 22'h2A_BCDE);
		regWrReady <= 1'b1;
		waitIdle();
		chk(rwq.size(), 1);
		chk(rwq[0].offs, 30'h0000_0123);
		chk(rwq[0].data, 32'hCAFE_F00D);
		chk(rwq[0].be, 4'hF);
		axr(8'h10, r);
		chk(r[21:0], 22'h00_0077);
	endtask : s_regw

	task automatic s_flush();
		clr();
		axw(8'h08, 32'h0000_2000);
		axw(8'h0C, 32'h0000_0001);
		enginesIdle <= 1'b0;
		put(hdr(OP_FLUSH, 23'h04_4102));
		put(32'h0000_1004);
		put(32'h8765_4321);
		put(32'h0BAD_BEEF);
		axw(8'h04, 32'(wp * 4));
		repeat (40) @(posedge clk);
		chk(mwq.size(), 0);
		chk(pmIdle, 1'b0);
		enginesIdle <= 1'b1;
		waitIdle();
		chk(mwq.size(), 1);
		chk(mwq[0].addr[31:3], 29'h0000_0200);
		chk(mwq[0].data, 64'h0BAD_BEEF_8765_4321);
		chk({mwq[0].qword, mwq[0].glob}, 2'b11);
		chk(tlbCnt, 1);
		chk(irqCnt, 1);
		chk(rwq[0].offs, CFG_OFFSET[31:2]);
	endtask : s_flush

	task automatic s_nowrite();
		clr();
		axw(8'h08, 32'h0000_0000);
		axw(8'h0C, 32'h0000_0000);
		put(hdr(OP_FLUSH, 23'h04_0102));
		put(32'h0000_1000);
		put(32'h0000_0000);
		put(32'h0000_0000);
		go();
		chk(mwq.size(), 0);
		chk(tlbCnt, 0);
		chk(irqCnt, 0);
	endtask : s_nowrite

	task automatic s_time();
		clr();
		put(hdr(OP_FLUSH, 23'h02_C002));
		put(32'h0000_2000);
		put(32'h0000_0000);
		put(32'h0000_0000);
		put(hdr(OP_FLUSH, 23'h20_4002));
		put(32'h0000_0040);
		put(32'h0000_0001);
		put(32'h0000_0000);
		go();
		chk(mwq.size(), 2);
		chk(mwq[0].data[63:36], 28'h000_0000);
		chk(mwq[0].glob, 1'b0);
		chk(purgeCnt, 1);
		chk(mwq[1].index, 1'b1);
	endtask : s_time

	task automatic s_sem();
		clr();
		semPass <= 1'b0;
		put(hdr(OP_MBOX, 23'h00_0001));
		put(32'h0000_0005);
		put(32'h0000_0800);
		axw(8'h04, 32'(wp * 4));
		repeat (40) @(posedge clk);
		chk(pmIdle, 1'b1);
		axr(8'h14, r);
		chk(r[0], 1'b0);
		semPass <= 1'b1;
		waitIdle();
		chk(mwq.size() + rwq.size(), 0);
	endtask : s_sem

	task automatic s_chain();
		clr();
		put(hdr(OP_REPHEAD, 23'h00_0000));
		put(hdr(OP_CHAIN, 23'h00_0000));
		put(32'h0000_0400);
		// Tagged pad that a working chain skips
		put(hdr(OP_PAD, 23'h40_0DEF));
		wp = 256;
		put(hdr(OP_PAD, 23'h40_0ABC));
		go();
		chk(mwq.size(), 1);
		chk(mwq[0].index, 1'b1);
		chk(mwq[0].data, 64'h0000_0000_0000_0404);
		axr(8'h10, r);
		chk(r[21:0], 22'h00_0ABC);
		chk(fetchGlobal, 1'b1);
		// Drop to per-process space, then try to climb back to global
		axw(8'h00, 32'h0000_0003);
		put(hdr(OP_CHAIN, 23'h00_0100));
		put(32'h0000_0480);
		wp = 288;
		put(hdr(OP_CHAIN, 23'h00_0000));
		put(32'h0000_04A0);
		wp = 296;
		put(hdr(OP_PAD, 23'h40_0123));
		put(hdr(OP_FLUSH, 23'h20_4001));
		put(32'h0000_0080);
		put(32'h0000_0005);
		go();
		chk(fetchGlobal, 1'b0);
		axr(8'h10, r);
		chk(r[21:0], 22'h00_0123);
		chk(mwq.size(), 2);
		chk({mwq[1].ppIndex, mwq[1].qword, mwq[1].glob}, 3'b100);
	endtask : s_chain

	initial begin
		{clk, rstn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
		{s_awaddr, s_araddr, s_wdata} = '0;
		s_wstrb = 4'hF;
		{enginesIdle, semPass, regWrReady} = 3'b111;
		wp = 0;
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		axw(8'h00, 32'h0000_0001);
		s_tag();
		s_regw();
		s_flush();
		s_nowrite();
		s_time();
		s_sem();
		s_chain();
		summarize();
	end
endmodule : tb_bcsp_parser
`default_nettype wire
